// File: design/clock_cond_pkg.sv
/*
 Constants and carriers for the clock conditioner configuration bank.
 Assumes one 50 MHz system clock and 32-bit serial words whose low four bits address a register.
*/
package clock_cond_pkg;
  localparam int WORD_W = 32;
  localparam int ADDR_W = 4;
  localparam int NUM_REGS = 16;
  localparam int NUM_CH = 5;
  // Register indices
  localparam logic [3:0] IDX_CH0 = 4'h0;
  localparam logic [3:0] IDX_SOFT_RESET = 4'h7;
  localparam logic [3:0] IDX_TUNE = 4'hA;
  localparam logic [3:0] IDX_REF_IN = 4'hB;
  localparam logic [3:0] IDX_LOOP1 = 4'hC;
  localparam logic [3:0] IDX_LOOP2_GLOBAL = 4'hD;
  localparam logic [3:0] IDX_OSC_REFDIV = 4'hE;
  localparam logic [3:0] IDX_FB_VCODIV = 4'hF;
  // Field positions
  localparam int POS_SOFT_RESET = 4;
  localparam int POS_SWING = 23;
  localparam int POS_B_STATE = 21;
  localparam int POS_A_STATE = 19;
  localparam int POS_CH_EN = 16;
  localparam int POS_TUNE_WAIT = 29;
  localparam int POS_IN1_BUF = 11;
  localparam int POS_IN0_BUF = 10;
  localparam int POS_LOS_FREQ = 8;
  localparam int POS_SIGNAL_LOSS_OUTPUT_TYPE = 6;
  localparam int POS_REF_SEL = 4;
  localparam int POS_P1_POL = 31;
  localparam int POS_P1_GAIN = 28;
  localparam int POS_P1_R = 16;
  localparam int POS_P1_N = 4;
  localparam int POS_XTAL = 21;
  localparam int POS_VCO_BUF = 20;
  localparam int POS_GLOBAL_EN = 18;
  localparam int POS_PWR_DOWN = 17;
  localparam int POS_DOUBLER = 16;
  localparam int POS_P2_HIZ = 15;
  localparam int POS_P1_HIZ = 14;
  localparam int POS_OSC_FREQ = 21;
  localparam int POS_LD_SEL = 16;
  localparam int POS_P2_R = 4;
  localparam int POS_P2_GAIN = 26;
  localparam int POS_VCO_DIV = 22;
  localparam int POS_P2_N = 4;
  // Silicon default words, address nibble zero
  localparam logic [31:0] RST_CH_EDGE = 32'h0000_0000;
  localparam logic [31:0] RST_CH_MID = 32'h0008_0000;
  localparam logic [31:0] RST_CH2 = 32'h0009_0000;
  localparam logic [31:0] RST_RESERVED = 32'h0000_0000;
  localparam logic [31:0] RST_TUNE = 32'h2000_0000;
  localparam logic [31:0] RST_REF_IN = 32'h0000_0DC0;
  localparam logic [31:0] RST_LOOP1 = 32'hE001_0010;
  localparam logic [31:0] RST_LOOP2_GLOBAL = 32'h0004_0000;
  localparam logic [31:0] RST_OSC_REFDIV = 32'h191F_0010;
  localparam logic [31:0] RST_FB_VCODIV = 32'h0880_0010;

  typedef struct packed {
    logic clk;
    logic data;
    logic latch;
  } prog_pins_t;

  typedef struct packed {
    logic diff_swing_level_sel;
    logic [1:0] single_ended_b_state;
    logic [1:0] single_ended_a_state;
    logic channel_output_enable;
  } channel_cfg_t;

  typedef struct packed {
    logic ref_in1_buffer_type;
    logic ref_in0_buffer_type;
    logic [1:0] signal_loss_min_freq;
    logic [1:0] signal_loss_output_type;
    logic [1:0] reference_source_select;
  } ref_cfg_t;

  typedef struct packed {
    logic first_pump_polarity;
    logic [2:0] first_pump_gain;
    logic [11:0] first_ref_divider;
    logic [11:0] first_feedback_divider;
  } loop1_cfg_t;

  typedef struct packed {
    logic crystal_support_enable;
    logic vco_buffer_enable;
    logic global_output_enable;
    logic power_down;
    logic second_ref_doubler_enable;
    logic second_pump_hiz;
    logic first_pump_hiz;
    logic [7:0] osc_input_frequency;
    logic [4:0] lock_indicator_select;
    logic [11:0] second_ref_divider;
    logic [1:0] second_pump_gain;
    logic [3:0] vco_output_divider;
    logic [17:0] second_feedback_divider;
  } loop2_cfg_t;

  typedef enum logic {
    TUNE_IDLE,
    TUNE_WAIT_LOCK
  } tune_state_t;
endpackage

// File: design/clock_cond_regs.sv
/*
 Configuration register bank of a two-loop clock conditioner, written over a
 three-wire serial port (clock, data, latch), MSB first, address in bits 3:0.
 Assumes the serial pins are asynchronous to clk and toggle slower than clk/4.
*/
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - Power on and reset request load every field with its silicon default.
// - Five identical channel registers, index 0 to 4, each steering its own output.
// - Channel bit 23 picks high differential swing, default standard swing.
// - Channels 1 to 3 hold output B state at 22:21, default inverted.
// - Channels 1 to 3 hold output A state at 20:19, default non-inverted.
// - Channel enable at bit 16, off by default except channel 2.
// - Register 10 bit 29, default 1, holds VCO tuning until first loop locks.
// - Register 11 bits 11 and 10 pick input buffer types, default MOS.
// - Register 11 bits 9:8 pick signal-loss minimum frequency, default 1.
// - Register 11 bits 7:6 pick signal-loss output type, default CMOS.
// - Register 11 bits 5:4 select reference source, default input 0.
// - Register 12 bit 31 sets first pump polarity, default positive.
// - Register 12 bits 30:28 set first pump gain, default 6.
// - First loop reference and feedback dividers at 27:16 and 15:4, default 1.
// - Register 13 doubler, crystal support and VCO buffer enables default off.
// - Register 13 global output enable bit 18 on, power down bit 17 off.
// - Register 13 pump high-impedance bits 15 and 14 default off.
// - Register 14 bits 28:21 give oscillator input frequency, default 200.
// - Register 14 lock pin select 20:16 default 31, second ref divider 15:4.
// - Register 15 pump gain, VCO divider and second feedback divider fields.
// - Writing reset bit in register 7 restores defaults and clears itself.
module clock_cond_regs
  import clock_cond_pkg::*;
(
  // System
  input wire logic clk,
  input wire logic rst_n,
  // Serial programming pins
  input wire prog_pins_t prog_pins,
  // First loop lock status
  input wire logic first_loop_locked,
  // Configuration outputs
  output var channel_cfg_t channel_cfg [NUM_CH],
  output var ref_cfg_t ref_cfg,
  output var loop1_cfg_t loop1_cfg,
  output var loop2_cfg_t loop2_cfg,
  output var logic tune_wait_for_lock,
  // VCO tuning trigger
  output logic tune_start
);

  function automatic logic [31:0] default_word(input logic [3:0] idx);
    logic [31:0] w;
    w = RST_RESERVED;
    case (idx)
      4'h0, 4'h4: w = RST_CH_EDGE;
      4'h1, 4'h3: w = RST_CH_MID;
      4'h2: w = RST_CH2;
      IDX_TUNE: w = RST_TUNE;
      IDX_REF_IN: w = RST_REF_IN;
      IDX_LOOP1: w = RST_LOOP1;
      IDX_LOOP2_GLOBAL: w = RST_LOOP2_GLOBAL;
      IDX_OSC_REFDIV: w = RST_OSC_REFDIV;
      IDX_FB_VCODIV: w = RST_FB_VCODIV;
      default: w = RST_RESERVED;
    endcase
    return w;
  endfunction

  function automatic logic hits(input logic wr, input logic [3:0] a, input logic [3:0] idx);
    return wr && (a == idx);
  endfunction

  // Pin synchronisers
  logic [2:0] sync_a;
  logic [2:0] sync_b;
  logic [2:0] hist;
  logic lock_a;
  logic lock_s;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sync_a <= 3'h0;
      sync_b <= 3'h0;
      hist <= 3'h0;
      lock_a <= 1'b0;
      lock_s <= 1'b0;
    end
    else
    begin
      sync_a <= {prog_pins.clk, prog_pins.data, prog_pins.latch};
      sync_b <= sync_a;
      hist <= sync_b;
      lock_a <= first_loop_locked;
      lock_s <= lock_a;
    end
  end

  wire sclk_rise = sync_b[2] && !hist[2];
  wire sdata = sync_b[1];
  wire latch_rise = sync_b[0] && !hist[0];

  // Serial shift register
  logic [31:0] shift;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      shift <= 32'h0000_0000;
    else if (sclk_rise)
      shift <= {shift[30:0], sdata};
  end

  wire wr_en = latch_rise;
  wire [3:0] wr_addr = shift[3:0];
  wire [31:0] wr_word = {shift[31:4], 4'h0};
  wire soft_reset = hits(wr_en, wr_addr, IDX_SOFT_RESET) && shift[POS_SOFT_RESET];

  // Register storage
  logic [31:0] regs [NUM_REGS];

  genvar g;
  generate
    for (g = 0; g < NUM_REGS; g++)
    begin : g_reg
      localparam logic [3:0] IDX = 4'(g);
      always_ff @(posedge clk or negedge rst_n)
      begin
        if (!rst_n)
          regs[g] <= default_word(IDX);
        else if (soft_reset)
          regs[g] <= default_word(IDX);
        else if (hits(wr_en, wr_addr, IDX))
          regs[g] <= wr_word;
      end
    end
  endgenerate

  generate
    for (g = 0; g < NUM_CH; g++)
    begin : g_ch
      assign channel_cfg[g].diff_swing_level_sel = regs[g][POS_SWING];
      assign channel_cfg[g].single_ended_b_state = regs[g][POS_B_STATE+:2];
      assign channel_cfg[g].single_ended_a_state = regs[g][POS_A_STATE+:2];
      assign channel_cfg[g].channel_output_enable = regs[g][POS_CH_EN];
    end
  endgenerate

  wire [31:0] w_tune = regs[IDX_TUNE];
  wire [31:0] w_ref = regs[IDX_REF_IN];
  wire [31:0] w_l1 = regs[IDX_LOOP1];
  wire [31:0] w_l2 = regs[IDX_LOOP2_GLOBAL];
  wire [31:0] w_osc = regs[IDX_OSC_REFDIV];
  wire [31:0] w_fb = regs[IDX_FB_VCODIV];

  assign tune_wait_for_lock = w_tune[POS_TUNE_WAIT];
  assign ref_cfg.ref_in1_buffer_type = w_ref[POS_IN1_BUF];
  assign ref_cfg.ref_in0_buffer_type = w_ref[POS_IN0_BUF];
  assign ref_cfg.signal_loss_min_freq = w_ref[POS_LOS_FREQ+:2];
  assign ref_cfg.signal_loss_output_type = w_ref[POS_SIGNAL_LOSS_OUTPUT_TYPE+:2];
  assign ref_cfg.reference_source_select = w_ref[POS_REF_SEL+:2];
  assign loop1_cfg.first_pump_polarity = w_l1[POS_P1_POL];
  assign loop1_cfg.first_pump_gain = w_l1[POS_P1_GAIN+:3];
  assign loop1_cfg.first_ref_divider = w_l1[POS_P1_R+:12];
  assign loop1_cfg.first_feedback_divider = w_l1[POS_P1_N+:12];
  assign loop2_cfg.crystal_support_enable = w_l2[POS_XTAL];
  assign loop2_cfg.vco_buffer_enable = w_l2[POS_VCO_BUF];
  assign loop2_cfg.second_ref_doubler_enable = w_l2[POS_DOUBLER];
  assign loop2_cfg.global_output_enable = w_l2[POS_GLOBAL_EN];
  assign loop2_cfg.power_down = w_l2[POS_PWR_DOWN];
  assign loop2_cfg.second_pump_hiz = w_l2[POS_P2_HIZ];
  assign loop2_cfg.first_pump_hiz = w_l2[POS_P1_HIZ];
  assign loop2_cfg.osc_input_frequency = w_osc[POS_OSC_FREQ+:8];
  assign loop2_cfg.lock_indicator_select = w_osc[POS_LD_SEL+:5];
  assign loop2_cfg.second_ref_divider = w_osc[POS_P2_R+:12];
  assign loop2_cfg.second_pump_gain = w_fb[POS_P2_GAIN+:2];
  assign loop2_cfg.vco_output_divider = w_fb[POS_VCO_DIV+:4];
  assign loop2_cfg.second_feedback_divider = w_fb[POS_P2_N+:18];

  // VCO tuning trigger after feedback divider update
  tune_state_t state;
  tune_state_t next_state;
  logic next_tune_start;
  wire fb_write = hits(wr_en, wr_addr, IDX_FB_VCODIV) && !soft_reset;

  always_comb
  begin
    next_state = state;
    next_tune_start = 1'b0;
    case (state)
      TUNE_IDLE:
      begin
        if (fb_write && tune_wait_for_lock && !lock_s)
          next_state = TUNE_WAIT_LOCK;
        else if (fb_write)
          next_tune_start = 1'b1;
      end
      TUNE_WAIT_LOCK:
      begin
        if (soft_reset)
          next_state = TUNE_IDLE;
        else if (lock_s)
        begin
          next_state = TUNE_IDLE;
          next_tune_start = 1'b1;
        end
      end
      default: next_state = TUNE_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state <= TUNE_IDLE;
      tune_start <= 1'b0;
    end
    else
    begin
      state <= next_state;
      tune_start <= next_tune_start;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  // Incoming word as a channel and the first loop see it
  wire [5:0] wr_ch_fields = {wr_word[23:19], wr_word[16]};
  wire [27:0] wr_body = wr_word[31:4];

  sequence s_soft_reset;
    soft_reset;
  endsequence

  sequence s_ch1_write;
    hits(wr_en, wr_addr, 4'h1) && !soft_reset;
  endsequence

  chk_soft_defaults: assert property (
    s_soft_reset |=> regs[IDX_LOOP1] == RST_LOOP1 && regs[IDX_OSC_REFDIV] == RST_OSC_REFDIV)
    else $error("defaults not restored after reset request");

  chk_reset_self_clear: assert property (
    s_soft_reset |=> !regs[IDX_SOFT_RESET][POS_SOFT_RESET])
    else $error("reset bit did not clear");

  chk_channel_isolation: assert property (
    s_ch1_write |=> $stable(channel_cfg[0]) && channel_cfg[1] == $past(wr_ch_fields))
    else $error("channel write reached wrong channel");

  chk_ch2_enable_default: assert property (
    s_soft_reset |=> channel_cfg[2].channel_output_enable && !channel_cfg[0].channel_output_enable)
    else $error("channel enable defaults wrong");

  chk_state_defaults: assert property (
    s_soft_reset |=> channel_cfg[1].single_ended_a_state == 2'h1
      && channel_cfg[3].single_ended_b_state == 2'h0)
    else $error("single-ended state defaults wrong");

  chk_hold_value: assert property (
    !wr_en |=> $stable(regs[IDX_REF_IN]) && $stable(regs[IDX_FB_VCODIV]))
    else $error("register changed without write");

  chk_wait_for_lock: assert property (
    state == TUNE_WAIT_LOCK && !lock_s |=> !tune_start)
    else $error("tuning started before lock");

  chk_lock_release: assert property (
    state == TUNE_WAIT_LOCK && lock_s && !soft_reset |=> tune_start ##1 !tune_start)
    else $error("tuning not released on lock");

  chk_immediate_tune: assert property (
    state == TUNE_IDLE && fb_write && !tune_wait_for_lock |=> tune_start)
    else $error("tuning not immediate when wait bit clear");

  chk_global_default: assert property (
    s_soft_reset |=> loop2_cfg.global_output_enable && !loop2_cfg.power_down
      && loop2_cfg.osc_input_frequency == 8'hC8)
    else $error("global control defaults wrong");

  chk_power_on: assert property (
    $rose(rst_n) |-> regs[IDX_LOOP1] == RST_LOOP1 && regs[IDX_FB_VCODIV] == RST_FB_VCODIV
      && regs[IDX_REF_IN] == RST_REF_IN && state == TUNE_IDLE)
    else $error("power-on defaults missing after reset release");

  chk_swing_default: assert property (
    s_soft_reset |=> !channel_cfg[0].diff_swing_level_sel && !channel_cfg[4].diff_swing_level_sel)
    else $error("swing level default wrong");

  chk_b_state_default: assert property (
    s_soft_reset |=> channel_cfg[1].single_ended_b_state == 2'h0
      && channel_cfg[2].single_ended_b_state == 2'h0)
    else $error("output B state default wrong");

  chk_a_state_default: assert property (
    s_soft_reset |=> channel_cfg[2].single_ended_a_state == 2'h1
      && channel_cfg[3].single_ended_a_state == 2'h1)
    else $error("output A state default wrong");

  chk_tune_default: assert property (
    s_soft_reset |=> tune_wait_for_lock)
    else $error("wait-for-lock default wrong");

  chk_buffer_default: assert property (
    s_soft_reset |=> ref_cfg.ref_in1_buffer_type && ref_cfg.ref_in0_buffer_type)
    else $error("input buffer type default wrong");

  chk_loss_freq_default: assert property (
    s_soft_reset |=> ref_cfg.signal_loss_min_freq == 2'h1)
    else $error("signal loss frequency default wrong");

  chk_loss_type_default: assert property (
    s_soft_reset |=> ref_cfg.signal_loss_output_type == 2'h3)
    else $error("signal loss output type default wrong");

  chk_ref_select_default: assert property (
    s_soft_reset |=> ref_cfg.reference_source_select == 2'h0)
    else $error("reference select default wrong");

  chk_pump1_polarity: assert property (
    s_soft_reset |=> loop1_cfg.first_pump_polarity)
    else $error("first pump polarity default wrong");

  chk_pump1_gain: assert property (
    s_soft_reset |=> loop1_cfg.first_pump_gain == 3'h6)
    else $error("first pump gain default wrong");

  chk_loop1_dividers: assert property (
    s_soft_reset |=> loop1_cfg.first_ref_divider == 12'h001
      && loop1_cfg.first_feedback_divider == 12'h001)
    else $error("first loop divider defaults wrong");

  chk_loop1_write: assert property (
    hits(wr_en, wr_addr, IDX_LOOP1) |=> loop1_cfg == $past(wr_body))
    else $error("first loop word not stored");

  chk_loop2_enables: assert property (
    s_soft_reset |=> !loop2_cfg.crystal_support_enable && !loop2_cfg.vco_buffer_enable
      && !loop2_cfg.second_ref_doubler_enable)
    else $error("second loop enable defaults wrong");

  chk_pump_hiz_default: assert property (
    s_soft_reset |=> !loop2_cfg.second_pump_hiz && !loop2_cfg.first_pump_hiz)
    else $error("pump high-impedance defaults wrong");

  chk_osc_freq_default: assert property (
    s_soft_reset |=> loop2_cfg.osc_input_frequency == 8'hC8)
    else $error("oscillator frequency default wrong");

  chk_lock_pin_default: assert property (
    s_soft_reset |=> loop2_cfg.lock_indicator_select == 5'h1F
      && loop2_cfg.second_ref_divider == 12'h001)
    else $error("lock pin select or divider default wrong");

  chk_loop2_feedback: assert property (
    s_soft_reset |=> loop2_cfg.second_pump_gain == 2'h2 && loop2_cfg.vco_output_divider == 4'h2
      && loop2_cfg.second_feedback_divider == 18'h00001)
    else $error("second loop field defaults wrong");

endmodule

`default_nettype wire

// File: tb/serial_host.sv
/*
 Host model that writes words into the bank over the three-wire programming port.
 Assumes the bank samples the pins with the same clk; every pin level is held five cycles.
*/
`timescale 1ns/1ps
`default_nettype none
module serial_host
  import clock_cond_pkg::*;
(
  // System
  input wire logic clk,
  // Programming pins
  output var prog_pins_t pins
);
  localparam int HOLD = 5;

  initial pins = '{clk: 1'b0, data: 1'b0, latch: 1'b0};

  // Reserved words keep zero, loss type zero on direct input select
  // host discipline
  function automatic logic [WORD_W-1:0] legal_word(input logic [WORD_W-1:0] w);
    logic [WORD_W-1:0] r;
    r = w;
    if (r[3:0] inside {4'h5, 4'h6, 4'h8, 4'h9})
      r[31:4] = '0;
    if (r[3:0] == IDX_REF_IN && r[5] == 1'b0)
      r[7:6] = 2'h0;
    return r;
  endfunction

  // Outlasts the synchroniser window of the bank
  task automatic hold_level();
    repeat (HOLD) @(posedge clk);
  endtask

  // Whole word, MSB first, then one latch pulse
  task automatic send_word(input logic [WORD_W-1:0] w);
    @(posedge clk);
    for (int i = WORD_W - 1; i >= 0; i--)
    begin
      pins.data <= w[i];
      pins.clk <= 1'b0;
      hold_level();
      pins.clk <= 1'b1;
      hold_level();
    end
    pins.clk <= 1'b0;
    pins.latch <= 1'b1;
    hold_level();
    pins.latch <= 1'b0;
    // Released data line shows the inverse of its last bit
    pins.data <= ~w[0];
    hold_level();
  endtask
endmodule
`default_nettype wire

// File: tb/tb_clock_conditioner_config_regs.sv
/*
 Self-checking bench for the configuration bank: defaults, random programming,
 reset request and the tuning trigger. Assumes serial_host drives the pins.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_clock_conditioner_config_regs
  import clock_cond_pkg::*;
;
  logic clk;
  logic rst_n;
  logic first_loop_locked;
  prog_pins_t pins;
  channel_cfg_t ch_cfg [NUM_CH];
  ref_cfg_t ref_o;
  loop1_cfg_t l1;
  loop2_cfg_t l2;
  logic wait_o;
  logic tstart;
  logic [31:0] shadow [16];
  logic [31:0] rnd;
  int bad_count;
  int check_count;
  int pulses;

  clock_cond_regs u_dut (
    .clk(clk), .rst_n(rst_n), .prog_pins(pins), .first_loop_locked(first_loop_locked),
    .channel_cfg(ch_cfg), .ref_cfg(ref_o), .loop1_cfg(l1), .loop2_cfg(l2),
    .tune_wait_for_lock(wait_o), .tune_start(tstart));
  serial_host u_host (.clk(clk), .pins(pins));

  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  always @(posedge clk)
    if (tstart === 1'b1)
      pulses++;

  function automatic logic [31:0] xs(input logic [31:0] x);
    logic [31:0] y;
    y = x ^ (x << 13);
    y = y ^ (y >> 17);
    return y ^ (y << 5);
  endfunction

  // Channels 0..4 or registers 10..15
  function automatic logic [3:0] idx_pick(input logic [31:0] x);
    logic [3:0] v;
    v = 4'(x % 11);
    return (v < 4'h5) ? v : v + 4'h5;
  endfunction

  function automatic logic [63:0] exp_l2();
    return 64'({shadow[13][21:20], shadow[13][18:14], shadow[14][28:4], shadow[15][27:4]});
  endfunction

  task automatic load_defaults();
    foreach (shadow[i])
      shadow[i] = 32'h0;
    for (int c = 1; c <= 3; c++)
      shadow[c][20:19] = 2'h1;
    shadow[2][16] = 1'b1;
    shadow[10][29] = 1'b1;
    shadow[11][11:4] = {1'b1, 1'b1, 2'h1, 2'h3, 2'h0};
    shadow[12][31:4] = {1'b1, 3'h6, 12'h001, 12'h001};
    shadow[13][18] = 1'b1;
    shadow[14][28:4] = {8'hC8, 5'h1F, 12'h001};
    shadow[15][27:4] = {2'h2, 4'h2, 18'h00001};
  endtask

  task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic check_all();
    for (int c = 0; c < NUM_CH; c++)
      check("channel_cfg", 64'(ch_cfg[c]), 64'({shadow[c][23:19], shadow[c][16]}));
    check("ref_cfg", 64'(ref_o), 64'(shadow[11][11:4]));
    check("loop1_cfg", 64'(l1), 64'(shadow[12][31:4]));
    check("loop2_cfg", 64'(l2), exp_l2());
    check("tune_wait", 64'(wait_o), 64'(shadow[10][29]));
  endtask

  task automatic write_reg(input logic [3:0] idx, input logic [27:0] body);
    logic [31:0] w;
    w = u_host.legal_word({body, idx});
    u_host.send_word(w);
    if (idx == IDX_SOFT_RESET && w[POS_SOFT_RESET])
      load_defaults();
    else if (idx != IDX_SOFT_RESET)
      shadow[idx] = w;
    #1;
  endtask

  task automatic tally_and_finish();
    if (bad_count == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  initial
  begin
    repeat (40000) @(posedge clk);
    bad_count++;
    tally_and_finish();
  end

  initial
  begin
    rst_n = 1'b0;
    first_loop_locked = 1'b0;
    bad_count = 0;
    check_count = 0;
    pulses = 0;
    rnd = 32'd65;
    load_defaults();
    repeat (10) @(posedge clk);
    #1;
    check_all();
    @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    check_all();
    // Corner values on one loop register, then random words
    write_reg(IDX_LOOP1, 28'hFFFFFFF);
    check_all();
    write_reg(IDX_LOOP1, 28'h0000000);
    check_all();
    for (int n = 0; n < 14; n++)
    begin
      rnd = xs(rnd);
      write_reg(idx_pick(rnd), rnd[31:4]);
      check_all();
    end
    // reserved word written with its reset contents
    write_reg(4'h5, rnd[31:4]);
    check_all();
    write_reg(IDX_SOFT_RESET, 28'h0000001);
    check_all();
    pulses = 0;
    // trigger held until the first loop locks
    write_reg(IDX_FB_VCODIV, 28'h0880001);
    check("tune_held", 64'(pulses), 64'h0);
    // reset request abandons the pending trigger
    write_reg(IDX_SOFT_RESET, 28'h0000001);
    @(posedge clk);
    first_loop_locked <= 1'b1;
    repeat (12) @(posedge clk);
    #1;
    check("tune_dropped", 64'(pulses), 64'h0);
    @(posedge clk);
    first_loop_locked <= 1'b0;
    write_reg(IDX_FB_VCODIV, 28'h0880001);
    check("tune_held_again", 64'(pulses), 64'h0);
    @(posedge clk);
    first_loop_locked <= 1'b1;
    repeat (12) @(posedge clk);
    #1;
    check("tune_on_lock", 64'(pulses), 64'h1);
    write_reg(IDX_FB_VCODIV, 28'h0880002);
    check("tune_locked", 64'(pulses), 64'h2);
    @(posedge clk);
    first_loop_locked <= 1'b0;
    write_reg(IDX_TUNE, 28'h0000000);
    write_reg(IDX_FB_VCODIV, 28'h0880003);
    check("tune_now", 64'(pulses), 64'h3);
    check_all();
    @(posedge clk);
    rst_n <= 1'b0;
    load_defaults();
    repeat (2) @(posedge clk);
    #1;
    check_all();
    @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    check_all();
    tally_and_finish();
  end
endmodule
`default_nettype wire
